// ---- rtl/pabm_pin_mux.sv ----
`timescale 1ns/1ps
// Function
// - Port A bit 2 is I/O or slave output enable, chosen by interface_config.
// - Output enable pin is input only; gates data bus drive; polarity bit 4.
// - Port A bit 3 is alternate wake-up; enable bit 1, polarity bit 4, function bit 7.
// - Suspended and wake enabled: pin transition restarts oscillator and interrupts CPU.
// - Wake enabled and pin asserted: suspend entry is refused.
// - Slave FIFO mode: port A bits 4,5 are input-only FIFO selects.
// - Port A bit 6 is packet commit input, polarity from bit 5.
// - Port A bit 7 is I/O, FIFO flag output or slave chip select.
// - Chip select deasserted: all other slave enables and strobes ignored.
// - FIFO or programmable mode: port B bits 0-2 become data bus bits 0-2.
module pabm_pin_mux
   import pabm_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic [1:0] interface_config_i,
   input wire logic [7:0] fifo_pin_polarity_i,
   input wire logic [7:0] wakeup_ctrl_i,
   input wire logic [7:0] port_a_config_i,
   input wire logic [7:0] port_a_output_enable_i,
   input wire logic [7:0] port_a_data_i,
   input wire logic [2:0] port_b_output_enable_i,
   input wire logic [2:0] port_b_data_i,
   input wire logic fifo_flag_i,
   input wire logic [2:0] fifo_wr_data_i,
   input wire logic fifo_drive_req_i,
   input wire logic suspend_req_i,
   input wire logic [7:0] port_a_pin_i,
   input wire logic [2:0] port_b_pin_i,
   output logic [7:0] port_a_pin_o,
   output logic [7:0] port_a_pin_oe_o,
   output logic [2:0] port_b_pin_o,
   output logic [2:0] port_b_pin_oe_o,
   output logic [7:0] port_a_read_o,
   output logic [2:0] port_b_read_o,
   output logic [2:0] fifo_rd_data_o,
   output logic slave_out_enable_o,
   output logic fifo_select_lo_o,
   output logic fifo_select_hi_o,
   output logic packet_commit_o,
   output logic slave_selected_o,
   output logic suspend_o,
   output logic osc_restart_o,
   output logic wake_irq_o
);

   // ------------------------------------------------------------------
   // Pin input synchronisers
   // ------------------------------------------------------------------
   logic [7:0] pa_sync;
   logic [2:0] pb_sync;

   pabm_sync #(.W(PA_W)) u_sync_a (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .d_i(port_a_pin_i),
      .q_o(pa_sync)
   );

   pabm_sync #(.W(FD_W)) u_sync_b (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .d_i(port_b_pin_i),
      .q_o(pb_sync)
   );

   // ------------------------------------------------------------------
   // Function selection
   // ------------------------------------------------------------------
   logic slave_mode;
   logic bus_mode;
   logic a3_wake_func;
   logic cs_active;
   logic oe_asserted;
   logic pkt_asserted;
   logic wake_en;
   logic wake_level;
   logic wake_prev_r;
   pabm_a7_mode_t a7_mode;

   assign slave_mode = (interface_config_i == IFCFG_SLAVE_FIFO);
   assign bus_mode = (interface_config_i == IFCFG_SLAVE_FIFO) ||
                     (interface_config_i == IFCFG_PROG);
   // The wake function owns the pin only while the port bit is not driven.
   assign a3_wake_func = wakeup_ctrl_i[WAKE_FUNC_BIT] & ~port_a_output_enable_i[PA_B3];
   assign wake_en = wakeup_ctrl_i[WAKE_EN_BIT];
   assign wake_level = pa_sync[PA_B3] ~^ wakeup_ctrl_i[WAKE_POL_BIT];

   always_comb begin
      a7_mode = PABM_A7_GPIO;
      if (slave_mode && port_a_config_i[PACFG_B7_BIT]) begin
         a7_mode = PABM_A7_FLAG;
      end else if (slave_mode) begin
         a7_mode = PABM_A7_CS;
      end
   end

   // Chip select counts as asserted when the pin is not configured as a select.
   assign cs_active = (a7_mode != PABM_A7_CS) | ~pa_sync[PA_B7];
   assign oe_asserted = slave_mode & cs_active &
                        (pa_sync[PA_B2] ~^ fifo_pin_polarity_i[POL_OE_BIT]);
   assign pkt_asserted = slave_mode & cs_active &
                         (pa_sync[PA_B6] ~^ fifo_pin_polarity_i[POL_PKT_BIT]);

   // ------------------------------------------------------------------
   // Pin drive
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         port_a_pin_o <= BYTE_ZERO;
         port_a_pin_oe_o <= BYTE_ZERO;
      end else begin
         port_a_pin_o <= port_a_data_i;
         port_a_pin_oe_o <= port_a_output_enable_i;
         if (slave_mode) begin
            port_a_pin_oe_o[PA_B2] <= 1'b0;
            port_a_pin_oe_o[PA_B4] <= 1'b0;
            port_a_pin_oe_o[PA_B5] <= 1'b0;
            port_a_pin_oe_o[PA_B6] <= 1'b0;
         end
         if (a3_wake_func) begin
            port_a_pin_oe_o[PA_B3] <= 1'b0;
         end
         if (a7_mode == PABM_A7_FLAG) begin
            port_a_pin_o[PA_B7] <= fifo_flag_i;
            port_a_pin_oe_o[PA_B7] <= 1'b1;
         end else if (a7_mode == PABM_A7_CS) begin
            port_a_pin_oe_o[PA_B7] <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         port_b_pin_o <= FD_ZERO;
         port_b_pin_oe_o <= FD_ZERO;
      end else if (bus_mode) begin
         port_b_pin_o <= fifo_wr_data_i;
         // In slave mode the external output enable gates the bus drive.
         port_b_pin_oe_o <= {FD_W{slave_mode ? oe_asserted : fifo_drive_req_i}};
      end else begin
         port_b_pin_o <= port_b_data_i;
         port_b_pin_oe_o <= port_b_output_enable_i;
      end
   end

   // ------------------------------------------------------------------
   // Decoded inputs
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         port_a_read_o <= BYTE_ZERO;
         port_b_read_o <= FD_ZERO;
         fifo_rd_data_o <= FD_ZERO;
         slave_out_enable_o <= 1'b0;
         fifo_select_lo_o <= 1'b0;
         fifo_select_hi_o <= 1'b0;
         packet_commit_o <= 1'b0;
         slave_selected_o <= 1'b0;
      end else begin
         port_a_read_o <= pa_sync;
         port_b_read_o <= pb_sync;
         fifo_rd_data_o <= bus_mode ? pb_sync : FD_ZERO;
         slave_out_enable_o <= oe_asserted;
         fifo_select_lo_o <= slave_mode & cs_active & pa_sync[PA_B4];
         fifo_select_hi_o <= slave_mode & cs_active & pa_sync[PA_B5];
         packet_commit_o <= pkt_asserted;
         slave_selected_o <= slave_mode & cs_active;
      end
   end

   // ------------------------------------------------------------------
   // Alternate wake-up
   // ------------------------------------------------------------------
   pabm_wake_state_t wk_state_r;

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         wake_prev_r <= 1'b0;
      end else begin
         wake_prev_r <= pa_sync[PA_B3];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         wk_state_r <= PABM_WK_RUN;
         suspend_o <= 1'b0;
         osc_restart_o <= 1'b0;
         wake_irq_o <= 1'b0;
      end else begin
         osc_restart_o <= 1'b0;
         wake_irq_o <= 1'b0;
         case (wk_state_r)
            PABM_WK_RUN: begin
               if (suspend_req_i && !(wake_en && a3_wake_func && wake_level)) begin
                  wk_state_r <= PABM_WK_SUSP;
                  suspend_o <= 1'b1;
               end
            end
            PABM_WK_SUSP: begin
               if (wake_en && a3_wake_func && (pa_sync[PA_B3] != wake_prev_r)) begin
                  wk_state_r <= PABM_WK_WAKE;
                  osc_restart_o <= 1'b1;
               end
            end
            PABM_WK_WAKE: begin
               wake_irq_o <= 1'b1;
               suspend_o <= 1'b0;
               wk_state_r <= PABM_WK_RUN;
            end
            default: begin
               wk_state_r <= PABM_WK_RUN;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   property p_reset_float;
      @(posedge ref_clk_i) reset_i |=>
      (port_a_pin_oe_o == BYTE_ZERO) && (port_b_pin_oe_o == FD_ZERO);
   endproperty
   a_reset_float: assert property (p_reset_float) else $error("pins driven after reset");

   property p_gpio_dir;
      @(posedge ref_clk_i) disable iff (reset_i)
      (interface_config_i == IFCFG_PORTS) ##1 (interface_config_i == IFCFG_PORTS)
      |-> port_b_pin_oe_o == $past(port_b_output_enable_i);
   endproperty
   a_gpio_dir: assert property (p_gpio_dir) else $error("port b direction wrong");

   property p_inputs_float;
      @(posedge ref_clk_i) disable iff (reset_i)
      slave_mode |=> !port_a_pin_oe_o[PA_B2] && !port_a_pin_oe_o[PA_B4] && !port_a_pin_oe_o[PA_B6];
   endproperty
   a_inputs_float: assert property (p_inputs_float) else $error("slave input driven");

   property p_flag_drive;
      @(posedge ref_clk_i) disable iff (reset_i)
      (a7_mode == PABM_A7_FLAG) |=>
      port_a_pin_oe_o[PA_B7] && port_a_pin_o[PA_B7] == $past(fifo_flag_i);
   endproperty
   a_flag_drive: assert property (p_flag_drive) else $error("flag not driven");

   property p_cs_gate;
      @(posedge ref_clk_i) disable iff (reset_i)
      !cs_active |=> !slave_out_enable_o && !packet_commit_o && !fifo_select_lo_o;
   endproperty
   a_cs_gate: assert property (p_cs_gate) else $error("strobe passed without select");

   property p_oe_gates_bus;
      @(posedge ref_clk_i) disable iff (reset_i)
      slave_mode && !oe_asserted |=> port_b_pin_oe_o == FD_ZERO;
   endproperty
   a_oe_gates_bus: assert property (p_oe_gates_bus) else $error("bus driven without oe");

   property p_pkt_pol;
      @(posedge ref_clk_i) disable iff (reset_i)
      slave_mode && cs_active && (pa_sync[PA_B6] == fifo_pin_polarity_i[POL_PKT_BIT])
      |=> packet_commit_o;
   endproperty
   a_pkt_pol: assert property (p_pkt_pol) else $error("packet commit missed");

   sequence s_wake_edge;
      wk_state_r == PABM_WK_SUSP && wake_en && a3_wake_func && pa_sync[PA_B3] != wake_prev_r;
   endsequence
   sequence s_wake_resp;
      osc_restart_o ##1 wake_irq_o;
   endsequence
   property p_wake;
      @(posedge ref_clk_i) disable iff (reset_i) s_wake_edge |=> s_wake_resp;
   endproperty
   a_wake: assert property (p_wake) else $error("wake-up not signalled");

   property p_no_susp;
      @(posedge ref_clk_i) disable iff (reset_i)
      wk_state_r == PABM_WK_RUN && wake_en && a3_wake_func && wake_level |=> !suspend_o;
   endproperty
   a_no_susp: assert property (p_no_susp) else $error("suspended while wake held");

endmodule

// ---- rtl/pabm_pkg.sv ----
package pabm_pkg;

   // ------------------------------------------------------------------
   // Interface configuration field encodings
   // ------------------------------------------------------------------
   localparam logic [1:0] IFCFG_PORTS = 2'h0;
   localparam logic [1:0] IFCFG_RSVD = 2'h1;
   localparam logic [1:0] IFCFG_PROG = 2'h2;
   localparam logic [1:0] IFCFG_SLAVE_FIFO = 2'h3;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int POL_OE_BIT = 4;
   localparam int POL_PKT_BIT = 5;
   localparam int WAKE_EN_BIT = 1;
   localparam int WAKE_POL_BIT = 4;
   localparam int WAKE_FUNC_BIT = 7;
   localparam int PACFG_B7_BIT = 7;
   localparam int PA_B2 = 2;
   localparam int PA_B3 = 3;
   localparam int PA_B4 = 4;
   localparam int PA_B5 = 5;
   localparam int PA_B6 = 6;
   localparam int PA_B7 = 7;

   // ------------------------------------------------------------------
   // Widths and reset values
   // ------------------------------------------------------------------
   localparam int PA_W = 8;
   localparam int FD_W = 3;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [2:0] FD_ZERO = 3'h0;

   typedef enum logic [1:0] {
      PABM_A7_GPIO = 2'b00,
      PABM_A7_FLAG = 2'b01,
      PABM_A7_CS = 2'b10
   } pabm_a7_mode_t;

   typedef enum logic [1:0] {
      PABM_WK_RUN = 2'b00,
      PABM_WK_SUSP = 2'b01,
      PABM_WK_WAKE = 2'b10
   } pabm_wake_state_t;

endpackage

// ---- rtl/pabm_sync.sv ----
`timescale 1ns/1ps
module pabm_sync #(
   parameter int W = 1
) (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] s1_r;

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         s1_r <= '0;
         q_o <= '0;
      end else begin
         s1_r <= d_i;
         q_o <= s1_r;
      end
   end
endmodule

// ---- bench/pabm_master_model.sv ----
`timescale 1ns/1ps
module pabm_master_model (
   input wire logic ref_clk_i,
   input wire logic cs_n_i,
   input wire logic oe_lvl_i,
   input wire logic [1:0] sel_i,
   input wire logic commit_lvl_i,
   input wire logic wake_lvl_i,
   input wire logic bus_drv_i,
   input wire logic [2:0] bus_data_i,
   input wire logic [7:0] dev_a_i,
   input wire logic [7:0] dev_a_oe_i,
   input wire logic [2:0] dev_b_i,
   input wire logic [2:0] dev_b_oe_i,
   output logic [7:0] pin_a_o,
   output logic [2:0] pin_b_o
);
   logic flip_r = 1'b0;
   logic [7:0] ext_a;
   logic [2:0] ext_b;
   // Lines nobody drives toggle every cycle, so a stale level never reads as valid.
   always_ff @(posedge ref_clk_i) begin
      flip_r <= ~flip_r;
   end
   // Strobe levels arrive already matched to the polarity the device is set for.
   assign ext_a = {cs_n_i, commit_lvl_i, sel_i, wake_lvl_i, oe_lvl_i, {2{flip_r}}};
   // The far side drives the bus only while the bench asks it to.
   assign ext_b = bus_drv_i ? bus_data_i : {3{flip_r}};
   assign pin_a_o = (dev_a_oe_i & dev_a_i) | (~dev_a_oe_i & ext_a);
   assign pin_b_o = (dev_b_oe_i & dev_b_i) | (~dev_b_oe_i & ext_b);
endmodule

// ---- bench/tb_port_ab_slave_fifo_pin_mux.sv ----
`timescale 1ns/1ps
module tb_port_ab_slave_fifo_pin_mux;
   import pabm_pkg::*;
   typedef struct {int cyc; logic [32:0] e; logic [32:0] m;} pabm_note_t;
   logic ref_clk_i = 1'b0, reset_i = 1'b1, flag = 1'b0, dreq = 1'b0, sreq = 1'b0;
   logic [1:0] cfg = 2'h0, sel = 2'h0;
   logic [7:0] pol = 8'h00, wk = 8'h00, pcfg = 8'h00, aoe = 8'h00, ad = 8'h00;
   logic [2:0] boe = 3'h0, bd = 3'h0, wd = 3'h0, bdat = 3'h0;
   logic cs_n = 1'b1, oe_l = 1'b0, cm_l = 1'b0, wake = 1'b0, bdrv = 1'b0;
   logic [7:0] pa_i, a_o, a_oe, a_rd;
   logic [2:0] pb_i, b_o, b_oe, b_rd, rd;
   logic soe, sl, sh, cm, ss, susp, osc, irq;
   logic [32:0] obs;
   logic [31:0] seed = 32'h000110d3;
   logic [31:0] r;
   int cyc = 0, error_cnt = 0, check_count = 0;
   pabm_note_t q[$];
   pabm_note_t n;

   assign obs = {a_oe, a_o, b_oe, b_o, rd, soe, sl, sh, cm, ss, susp, osc, irq};

   pabm_pin_mux u_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .interface_config_i(cfg),
      .fifo_pin_polarity_i(pol), .wakeup_ctrl_i(wk), .port_a_config_i(pcfg),
      .port_a_output_enable_i(aoe), .port_a_data_i(ad), .port_b_output_enable_i(boe),
      .port_b_data_i(bd), .fifo_flag_i(flag), .fifo_wr_data_i(wd), .fifo_drive_req_i(dreq),
      .suspend_req_i(sreq), .port_a_pin_i(pa_i), .port_b_pin_i(pb_i), .port_a_pin_o(a_o),
      .port_a_pin_oe_o(a_oe), .port_b_pin_o(b_o), .port_b_pin_oe_o(b_oe), .port_a_read_o(a_rd),
      .port_b_read_o(b_rd), .fifo_rd_data_o(rd), .slave_out_enable_o(soe),
      .fifo_select_lo_o(sl), .fifo_select_hi_o(sh), .packet_commit_o(cm),
      .slave_selected_o(ss), .suspend_o(susp), .osc_restart_o(osc), .wake_irq_o(irq));

   pabm_master_model u_master (.ref_clk_i(ref_clk_i), .cs_n_i(cs_n), .oe_lvl_i(oe_l),
      .sel_i(sel), .commit_lvl_i(cm_l), .wake_lvl_i(wake), .bus_drv_i(bdrv),
      .bus_data_i(bdat), .dev_a_i(a_o), .dev_a_oe_i(a_oe), .dev_b_i(b_o), .dev_b_oe_i(b_oe),
      .pin_a_o(pa_i), .pin_b_o(pb_i));

   initial begin
      forever #5 ref_clk_i = ~ref_clk_i;
   end

   always @(posedge ref_clk_i) cyc <= cyc + 1;

   // ------------------------------------------------------------------
   // Result watcher
   // ------------------------------------------------------------------
   always @(posedge ref_clk_i) begin
      #2;
      while (q.size() > 0 && q[0].cyc <= cyc) begin
         n = q.pop_front();
         check_count++;
         if ((obs & n.m) !== (n.e & n.m)) begin
            error_cnt++;
            $display("[FAIL] %0t outputs %h expected %h mask %h", $time, obs, n.e, n.m);
         end
      end
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [32:0] mk(logic [7:0] x, logic [7:0] y, logic [2:0] u,
         logic [2:0] v, logic [2:0] w, logic [7:0] c);
      return {x, y, u, v, w, c};
   endfunction

   task automatic note(int d, logic [32:0] e, logic [32:0] m);
      q.push_back('{cyc + d, e, m});
   endtask

   task automatic tick(int k);
      repeat (k) @(posedge ref_clk_i);
      #1;
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      repeat (3000) @(posedge ref_clk_i);
      error_cnt++;
      $display("[FAIL] %0t run did not finish", $time);
      give_verdict();
   end

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      note(1, '0, '1);
      tick(3);
      reset_i = 1'b0;
      note(1, '0, '1);
      for (int i = 0; i < 4; i++) begin
         tick(4);
         r = rnd();
         cfg = i[0] ? IFCFG_RSVD : IFCFG_PORTS;
         {bd, boe, ad, aoe} = r[21:0];
         note(4, mk(aoe, ad, boe, bd, 3'h0, 8'h00), mk(8'hff, aoe, 3'h7, boe, 3'h7, 8'hff));
      end
      tick(4);
      $display("test port mode done");
      {cfg, aoe, wd, flag} = {IFCFG_SLAVE_FIFO, 8'hff, r[24:22], r[25]};
      for (int p = 0; p < 4; p++) begin
         tick(4);
         pol = {2'h0, p[1:0], 4'h0};
         {cs_n, oe_l, cm_l, sel, bdrv, bdat} = {1'b0, p[0], p[1], p[1:0], 1'b0, r[p+2 -: 3]};
         note(4, mk(8'h0b, ad, 3'h7, wd, 3'h0, {1'b1, p[0], p[1], 5'h18}),
            mk(8'hff, 8'h0b, 3'h7, 3'h7, 3'h0, 8'hff));
         tick(4);
         {oe_l, cm_l, bdrv} = {~p[0], ~p[1], 1'b1};
         // The bus reaches the read path only after the device has stopped driving it.
         note(6, mk(8'h0b, ad, 3'h0, 3'h0, bdat, {1'b0, p[0], p[1], 5'h08}),
            mk(8'hff, 8'h0b, 3'h7, 3'h0, 3'h7, 8'hff));
         tick(6);
         {cs_n, oe_l, cm_l, bdrv} = {1'b1, p[0], p[1], 1'b0};
         note(4, mk(8'h0b, ad, 3'h0, 3'h0, 3'h0, 8'h00),
            mk(8'hff, 8'h0b, 3'h7, 3'h0, 3'h0, 8'hff));
      end
      tick(4);
      pcfg = 8'h80;
      note(4, mk(8'h8b, {flag, 7'h0}, 3'h7, wd, 3'h0, 8'hf0),
         mk(8'hff, 8'h80, 3'h7, 3'h7, 3'h0, 8'hf7));
      $display("test slave mode done");
      tick(4);
      {cfg, pcfg, dreq} = {IFCFG_PROG, 8'h00, 1'b1};
      note(4, mk(8'h0, 8'h0, 3'h7, wd, 3'h0, 8'h00), mk(8'h0, 8'h0, 3'h7, 3'h7, 3'h0, 8'hf8));
      tick(4);
      {dreq, bdrv} = {1'b0, 1'b1};
      note(4, mk(8'h0, 8'h0, 3'h0, 3'h0, bdat, 8'h00), mk(8'h0, 8'h0, 3'h7, 3'h0, 3'h7, 8'hf8));
      $display("test programmable mode done");
      tick(4);
      check_count++;
      if (b_rd !== bdat) begin
         error_cnt++;
         $display("[FAIL] %0t port b read %h expected %h", $time, b_rd, bdat);
      end
      {cfg, aoe, wk, sreq, bdrv} = {IFCFG_PORTS, 8'h00, 8'h92, 1'b1, 1'b0};
      note(4, mk(8'h0, 8'h0, 3'h0, 3'h0, 3'h0, 8'h04), mk(8'h0, 8'h0, 3'h0, 3'h0, 3'h0, 8'h07));
      tick(5);
      wake = 1'b1;
      for (int k = 0; k < 8 && osc !== 1'b1; k++) tick(1);
      if (osc !== 1'b1) begin
         error_cnt++;
         $display("[FAIL] %0t no oscillator restart after wake edge", $time);
         give_verdict();
      end
      check_count++;
      if (a_rd[PA_B3] !== 1'b1) begin
         error_cnt++;
         $display("[FAIL] %0t port a read misses wake pin level", $time);
      end
      note(0, mk(8'h0, 8'h0, 3'h0, 3'h0, 3'h0, 8'h06), mk(8'h0, 8'h0, 3'h0, 3'h0, 3'h0, 8'h07));
      note(1, mk(8'h0, 8'h0, 3'h0, 3'h0, 3'h0, 8'h01), mk(8'h0, 8'h0, 3'h0, 3'h0, 3'h0, 8'h07));
      note(6, mk(8'h0, 8'h0, 3'h0, 3'h0, 3'h0, 8'h00), mk(8'h0, 8'h0, 3'h0, 3'h0, 3'h0, 8'h04));
      tick(8);
      wake = 1'b0;
      note(6, mk(8'h0, 8'h0, 3'h0, 3'h0, 3'h0, 8'h04), mk(8'h0, 8'h0, 3'h0, 3'h0, 3'h0, 8'h04));
      tick(8);
      $display("test wake-up done");
      give_verdict();
   end
endmodule
